// File: rtl/synth_sysref_channel_divide_code_ramp_cfg.sv
// Purpose: Configuration bank for reference pulses, channel divider,
//          calibration seeding and ramp limits
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Decoded outputs lag a register write by one cycle
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module synth_sysref_channel_divide_code_ramp_cfg
    import synth_cfg_pkg::*;
#(
    parameter int                   CORE_W       = 3,
    parameter int                   CURRENT_W    = 9,
    parameter logic [CORE_W-1:0]    CORE_DEFAULT = '0,
    parameter logic [CURRENT_W-1:0] CURR_DEFAULT = '0
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output      logic [DATA_W-1:0]    reg_rdata,
    input  wire logic                 ramp_enable,
    input  wire logic [7:0]           last_cap_code,
    input  wire logic [CORE_W-1:0]    last_core_sel,
    input  wire logic [CURRENT_W-1:0] last_current_code,
    input  wire logic                 cap_override_valid,
    input  wire logic [7:0]           cap_override_code,
    output      logic [2:0]           sysref_prescale_ratio,
    output      logic                 sysref_prescale_valid,
    output      logic                 sysref_generation_enable,
    output      logic                 sysref_master_mode,
    output      logic                 sysref_pulser_active,
    output      logic [12:0]          sysref_divide_ratio,
    output      logic [5:0]           sysref_delay_weight_1,
    output      logic [5:0]           sysref_delay_weight_2,
    output      logic [5:0]           sysref_delay_weight_3,
    output      logic [5:0]           sysref_delay_weight_4,
    output      logic [3:0]           sysref_burst_length,
    output      logic                 segment_driver_enable,
    output      logic [9:0]           channel_divide_ratio,
    output      logic                 channel_divide_valid,
    output      logic [32:0]          ramp_recal_threshold,
    output      logic                 fast_recal_enable,
    output      logic [7:0]           oscillator_cap_code,
    output      logic [CORE_W-1:0]    oscillator_core_sel,
    output      logic [CURRENT_W-1:0] oscillator_current_code,
    output      logic                 ramp_limits_active,
    output      logic [32:0]          ramp_upper_limit,
    output      logic [32:0]          ramp_lower_limit
);

    ////////////////////////////////////////////////////////////////////
    // Functions

    // Address to storage index, IDX_NONE on a miss
    function automatic logic [3:0] addr_to_index(
        input logic [ADDR_W-1:0] a
    );
        logic [3:0] idx;
        idx = IDX_NONE;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (a == REG_OFFSET[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // Channel divide code to ratio, zero for reserved codes
    function automatic logic [9:0] channel_divide_code_ratio(input logic [4:0] code);
        logic [9:0] r;
        r = 10'h000;
        unique case (code)
            5'h00:   r = 10'h002;
            5'h01:   r = 10'h004;
            5'h02:   r = 10'h006;
            5'h03:   r = 10'h008;
            5'h04:   r = 10'h00C;
            5'h05:   r = 10'h010;
            5'h06:   r = 10'h018;
            5'h07:   r = 10'h020;
            5'h08:   r = 10'h030;
            5'h09:   r = 10'h040;
            5'h0A:   r = 10'h048;
            5'h0B:   r = 10'h060;
            5'h0C:   r = 10'h080;
            5'h0D:   r = 10'h0C0;
            5'h0E:   r = 10'h100;
            5'h0F:   r = 10'h180;
            5'h10:   r = 10'h200;
            5'h11:   r = 10'h300;
            default: r = 10'h000;   // Reserved codes
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register storage
    logic [DATA_W-1:0] regs_reg [NUM_REGS];   // Stored register words
    wire logic [3:0]   wr_idx;                // Write target index
    wire logic [3:0]   rd_idx;                // Read source index

    assign wr_idx = addr_to_index(reg_addr);
    assign rd_idx = wr_idx;

    // One process per register; writes only touch writable bits
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_store
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                regs_reg[g] <= REG_RESET[g];
            end else if (reg_write && wr_idx == 4'(g)) begin
                regs_reg[g] <= (reg_wdata & REG_MASK[g]) | REG_FIXED[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Field extraction
    wire logic [2:0]  pre_sel;       // Prescaler select code
    wire logic        pulse_bit;     // Pulser enable
    wire logic        gen_bit;       // Generation enable
    wire logic        repeat_bit;    // Repeater select
    wire logic [10:0] main_div;      // Main divider value
    wire logic [5:0]  w1;            // Delay weight 1
    wire logic [5:0]  w2;            // Delay weight 2
    wire logic [5:0]  w3;            // Delay weight 3
    wire logic [5:0]  w4;            // Delay weight 4
    wire logic [3:0]  burst;         // Pulses per request
    wire logic        seg_bit;       // Segment driver enable
    wire logic [4:0]  channel_divide_code_code;    // Channel divide code
    wire logic        fast_bit;      // Fast recalibration
    wire logic [7:0]  cap_start;     // Start cap code
    wire logic [32:0] threshold;     // Assembled threshold
    wire logic [32:0] upper_lim;     // Assembled upper limit
    wire logic [32:0] lower_lim;     // Assembled lower limit

    assign pre_sel    = regs_reg[IDX_SR_MODE][PRE_LSB +: 3];
    assign pulse_bit  = regs_reg[IDX_SR_MODE][PULSE_BIT];
    assign gen_bit    = regs_reg[IDX_SR_MODE][GEN_BIT];
    assign repeat_bit = regs_reg[IDX_SR_MODE][REPEAT_BIT];
    assign main_div   = regs_reg[IDX_SR_DIV][10:0];
    assign w1         = regs_reg[IDX_SR_DLY_A][W1_LSB +: 6];
    assign w2         = regs_reg[IDX_SR_DLY_A][W2_LSB +: 6];
    assign w3         = regs_reg[IDX_SR_DLY_B][W1_LSB +: 6];
    assign w4         = regs_reg[IDX_SR_DLY_B][W2_LSB +: 6];
    assign burst      = regs_reg[IDX_SR_DLY_B][BURST_LSB +: 4];
    assign seg_bit    = regs_reg[IDX_CHANNEL_DIVIDE_CODE_SEG][SEG_BIT];
    assign channel_divide_code_code = regs_reg[IDX_CHANNEL_DIVIDE_CODE_RAT][CHANNEL_DIVIDE_CODE_LSB +: 5];
    assign fast_bit   = regs_reg[IDX_CAL_CTRL][FAST_BIT];
    assign cap_start  = regs_reg[IDX_CAL_CTRL][CAP_LSB +: 8];

    assign threshold = {regs_reg[IDX_CAL_CTRL][THR_TOP],
                        regs_reg[IDX_THR_MID], regs_reg[IDX_THR_LOW]};
    assign upper_lim = {regs_reg[IDX_UPL_TOP][0],
                        regs_reg[IDX_UPL_MID], regs_reg[IDX_UPL_LOW]};
    assign lower_lim = {regs_reg[IDX_LOL_TOP][0],
                        regs_reg[IDX_LOL_MID], regs_reg[IDX_LOL_LOW]};

    ////////////////////////////////////////////////////////////////////
    // Decoding
    wire logic        pre_ok;        // Prescaler code legal
    wire logic [12:0] div_ratio;     // Main divide ratio
    wire logic [9:0]  ch_ratio;      // Channel divide ratio
    wire logic        ch_ok;         // Channel code legal
    wire logic        master;        // Master role
    wire logic [7:0]  dly_sum;       // Sum of all four weights
    wire logic [2:0]  dly_zeros;     // Count of zero weights
    wire logic        dly_bad;       // Weight setting broken
    wire logic        seg_bad;       // Segment setting broken
    wire logic        cap_bad;       // Start cap code too high
    wire logic [DATA_W-1:0] status;  // Live check flags

    assign pre_ok = (pre_sel == 3'h1) || (pre_sel == 3'h2) ||
                    (pre_sel == 3'h4);
    assign div_ratio = SR_DIV_BASE + {1'b0, main_div, 1'b0};
    assign ch_ratio = channel_divide_code_ratio(channel_divide_code_code);
    assign ch_ok    = channel_divide_code_code <= CHANNEL_DIVIDE_CODE_LAST;
    assign master = ~repeat_bit;

    assign dly_sum   = 8'(w1) + 8'(w2) + 8'(w3) + 8'(w4);
    assign dly_zeros = 3'(w1 == 6'h00) + 3'(w2 == 6'h00) +
                       3'(w3 == 6'h00) + 3'(w4 == 6'h00);
    assign dly_bad   = (dly_zeros < 3'h2) || (dly_sum != DELAY_SUM);
    assign seg_bad   = ch_ok && (ch_ratio == CHANNEL_DIVIDE_CODE_MIN_RAT ? 1'b0 :
                                 ~seg_bit);
    assign cap_bad   = cap_start > CAP_CODE_MAX;

    assign status = DATA_W'({cap_bad, seg_bad, dly_bad, ~ch_ok, ~pre_ok});

    ////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe, zero when unmapped
    wire logic [DATA_W-1:0] rd_word;   // Selected read word
    wire logic              rd_hit;    // Stored register addressed

    assign rd_hit  = rd_idx != IDX_NONE;
    assign rd_word = rd_hit ? regs_reg[rd_idx] :
                     (reg_addr == STATUS_OFFSET) ? status :
                     16'h0000;

    // Read data register, held at zero between reads
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            reg_rdata <= rd_word;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reference pulse outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sysref_prescale_ratio    <= 3'h4;
            sysref_prescale_valid    <= 1'b1;
            sysref_generation_enable <= 1'b0;
            sysref_master_mode       <= 1'b1;
            sysref_pulser_active     <= 1'b0;
            sysref_divide_ratio      <= SR_DIV_BASE;
        end else begin
            sysref_prescale_ratio    <= pre_ok ? pre_sel : 3'h0;
            sysref_prescale_valid    <= pre_ok;
            sysref_generation_enable <= gen_bit;
            sysref_master_mode       <= master;
            sysref_pulser_active     <= pulse_bit & master;
            sysref_divide_ratio      <= div_ratio;
        end
    end

    // Delay weights and burst length
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sysref_delay_weight_1 <= 6'h3F;
            sysref_delay_weight_2 <= 6'h00;
            sysref_delay_weight_3 <= 6'h00;
            sysref_delay_weight_4 <= 6'h00;
            sysref_burst_length   <= 4'h0;
        end else begin
            sysref_delay_weight_1 <= w1;
            sysref_delay_weight_2 <= w2;
            sysref_delay_weight_3 <= w3;
            sysref_delay_weight_4 <= w4;
            sysref_burst_length   <= (pulse_bit & master) ? burst : 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Channel divider outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            segment_driver_enable <= 1'b0;
            channel_divide_ratio  <= CHANNEL_DIVIDE_CODE_MIN_RAT;
            channel_divide_valid  <= 1'b1;
        end else begin
            segment_driver_enable <= seg_bit;
            channel_divide_ratio  <= ch_ratio;
            channel_divide_valid  <= ch_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Calibration and ramp outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ramp_recal_threshold <= '0;
            fast_recal_enable    <= 1'b0;
            ramp_limits_active   <= 1'b0;
            ramp_upper_limit     <= '0;
            ramp_lower_limit     <= '0;
        end else begin
            ramp_recal_threshold <= threshold;
            fast_recal_enable    <= fast_bit;
            ramp_limits_active   <= ramp_enable;
            ramp_upper_limit     <= ramp_enable ? upper_lim : 33'h0;
            ramp_lower_limit     <= ramp_enable ? lower_lim : 33'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Calibration seed selection
    cal_seed_if #(
        .CORE_W    (CORE_W),
        .CURRENT_W (CURRENT_W)
    ) seed_bus ();

    assign seed_bus.fast_recal_enable = fast_bit;
    assign seed_bus.cap_code_start    = cap_start;

    cal_seed_select #(
        .CORE_W       (CORE_W),
        .CURRENT_W    (CURRENT_W),
        .CORE_DEFAULT (CORE_DEFAULT),
        .CURR_DEFAULT (CURR_DEFAULT)
    ) u_seed (
        .clk                (clk),
        .sys_rst            (sys_rst),
        .seed               (seed_bus.sel),
        .last_cap_code      (last_cap_code),
        .last_core_sel      (last_core_sel),
        .last_current_code  (last_current_code),
        .cap_override_valid (cap_override_valid),
        .cap_override_code  (cap_override_code)
    );

    // Seed outputs come straight from the selector flops
    assign oscillator_cap_code     = seed_bus.seed_cap;
    assign oscillator_core_sel     = seed_bus.seed_core;
    assign oscillator_current_code = seed_bus.seed_current;

endmodule

// File: rtl/synth_cfg_pkg.sv
// Purpose: Shared constants of the synthesizer configuration bank
// Assumes: 16-bit registers on a 7-bit word address
// Notes:   Fixed bits are folded into the reset and readback values
package synth_cfg_pkg;

    ////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int ADDR_W   = 7;                // Register address width
    localparam int DATA_W   = 16;               // Register data width
    localparam int NUM_REGS = 15;               // Stored registers

    ////////////////////////////////////////////////////////////////////
    // Register indices into the storage array
    localparam logic [3:0] IDX_CHANNEL_DIVIDE_CODE_SEG = 4'h0;
    localparam logic [3:0] IDX_SR_MODE   = 4'h1;
    localparam logic [3:0] IDX_SR_DIV    = 4'h2;
    localparam logic [3:0] IDX_SR_DLY_A  = 4'h3;
    localparam logic [3:0] IDX_SR_DLY_B  = 4'h4;
    localparam logic [3:0] IDX_CHANNEL_DIVIDE_CODE_RAT = 4'h5;
    localparam logic [3:0] IDX_CAL_CTRL  = 4'h6;
    localparam logic [3:0] IDX_THR_MID   = 4'h7;
    localparam logic [3:0] IDX_THR_LOW   = 4'h8;
    localparam logic [3:0] IDX_UPL_TOP   = 4'h9;
    localparam logic [3:0] IDX_UPL_MID   = 4'hA;
    localparam logic [3:0] IDX_UPL_LOW   = 4'hB;
    localparam logic [3:0] IDX_LOL_TOP   = 4'hC;
    localparam logic [3:0] IDX_LOL_MID   = 4'hD;
    localparam logic [3:0] IDX_LOL_LOW   = 4'hE;
    localparam logic [3:0] IDX_NONE      = 4'hF;   // No stored register

    // Offsets, in index order
    localparam logic [ADDR_W-1:0] REG_OFFSET [NUM_REGS] = '{
        7'h1F, 7'h47, 7'h48, 7'h49, 7'h4A, 7'h4B, 7'h4E, 7'h4F,
        7'h50, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55, 7'h56};
    // Read-only live check flags
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 7'h57;

    // Writable bits of each register
    localparam logic [DATA_W-1:0] REG_MASK [NUM_REGS] = '{
        16'h4000, 16'h00FC, 16'h07FF, 16'h0FFF, 16'hFFFF, 16'h07C0,
        16'h0BFE, 16'hFFFF, 16'hFFFF, 16'h0001, 16'hFFFF, 16'hFFFF,
        16'h0001, 16'hFFFF, 16'hFFFF};
    // Constant bits that always read back
    localparam logic [DATA_W-1:0] REG_FIXED [NUM_REGS] = '{
        16'h03EC, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0800,
        16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000};
    // Values after reset, fixed bits included
    localparam logic [DATA_W-1:0] REG_RESET [NUM_REGS] = '{
        16'h03EC, 16'h0081, 16'h0000, 16'h003F, 16'h0000, 16'h0800,
        16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000};

    ////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int PRE_LSB    = 5;     // Prescaler select, 3 bits
    localparam int PULSE_BIT  = 4;     // Pulser enable
    localparam int GEN_BIT    = 3;     // Generation enable
    localparam int REPEAT_BIT = 2;     // Repeater select
    localparam int W1_LSB     = 0;     // Delay weights 1 and 3
    localparam int W2_LSB     = 6;     // Delay weights 2 and 4
    localparam int BURST_LSB  = 12;    // Burst length, 4 bits
    localparam int SEG_BIT    = 14;    // Segment driver enable
    localparam int CHANNEL_DIVIDE_CODE_LSB  = 6;     // Channel divide code, 5 bits
    localparam int THR_TOP    = 11;    // Threshold bit 32
    localparam int FAST_BIT   = 9;     // Fast recalibration enable
    localparam int CAP_LSB    = 1;     // Start cap code, 8 bits

    // Limits and offsets
    localparam logic [7:0]  CAP_CODE_MAX   = 8'hB7;   // 183
    localparam logic [7:0]  DELAY_SUM      = 8'h3F;   // 63
    localparam logic [12:0] SR_DIV_BASE    = 13'h0004;
    localparam logic [4:0]  CHANNEL_DIVIDE_CODE_LAST     = 5'h11;   // 17
    localparam logic [9:0]  CHANNEL_DIVIDE_CODE_MIN_RAT  = 10'h002;

    // Status bit positions
    localparam int ST_PRE_BAD = 0;
    localparam int ST_CHANNEL_DIVIDE_CODE_BAD = 1;
    localparam int ST_DLY_BAD = 2;
    localparam int ST_SEG_BAD = 3;
    localparam int ST_CAP_BAD = 4;

endpackage

// File: rtl/cal_seed_if.sv
// Purpose: Carries calibration seed settings between bank and selector
// Assumes: One clock domain
// Notes:   Bank drives settings, selector drives registered seeds
`timescale 1ns/1ps
interface cal_seed_if #(
    parameter int CORE_W    = 3,
    parameter int CURRENT_W = 9
);
    logic                 fast_recal_enable;  // Start from last values
    logic [7:0]           cap_code_start;     // Default cap seed
    logic [7:0]           seed_cap;           // Chosen cap seed
    logic [CORE_W-1:0]    seed_core;          // Chosen core seed
    logic [CURRENT_W-1:0] seed_current;       // Chosen current seed

    // Bank side
    modport cfg (output fast_recal_enable, output cap_code_start,
                 input seed_cap, input seed_core, input seed_current);
    // Selector side
    modport sel (input fast_recal_enable, input cap_code_start,
                 output seed_cap, output seed_core, output seed_current);
endinterface

// File: rtl/cal_seed_select.sv
// Purpose: Picks the starting values for the oscillator calibration
// Assumes: Last-used codes come from the calibration engine
// Notes:   Seeds are registered, one cycle behind their inputs
`timescale 1ns/1ps
module cal_seed_select
    import synth_cfg_pkg::*;
#(
    parameter int              CORE_W        = 3,
    parameter int              CURRENT_W     = 9,
    parameter logic [CORE_W-1:0]    CORE_DEFAULT  = '0,
    parameter logic [CURRENT_W-1:0] CURR_DEFAULT  = '0
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    cal_seed_if.sel                   seed,
    input  wire logic [7:0]           last_cap_code,
    input  wire logic [CORE_W-1:0]    last_core_sel,
    input  wire logic [CURRENT_W-1:0] last_current_code,
    input  wire logic                 cap_override_valid,
    input  wire logic [7:0]           cap_override_code
);

    ////////////////////////////////////////////////////////////////////
    // Seed choice
    wire logic [7:0]           cap_next;      // Cap seed candidate
    wire logic [CORE_W-1:0]    core_next;     // Core seed candidate
    wire logic [CURRENT_W-1:0] current_next;  // Current seed candidate

    assign cap_next     = cap_override_valid ? cap_override_code :
                          seed.fast_recal_enable ? last_cap_code :
                          seed.cap_code_start;
    assign core_next    = seed.fast_recal_enable ? last_core_sel :
                          CORE_DEFAULT;
    assign current_next = seed.fast_recal_enable ? last_current_code :
                          CURR_DEFAULT;

    // Seed registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seed.seed_cap     <= '0;
            seed.seed_core    <= '0;
            seed.seed_current <= '0;
        end else begin
            seed.seed_cap     <= cap_next;
            seed.seed_core    <= core_next;
            seed.seed_current <= current_next;
        end
    end

endmodule

// File: verification/synth_cfg_sva.sv
// Purpose: Port checks of the configuration bank
// Assumes: Decoded outputs show two edges after a write strobe
// Notes:   Bound to every bank instance
`timescale 1ns/1ps
module synth_cfg_sva
    import synth_cfg_pkg::*;
(
    input wire logic              clk, sys_rst, reg_write, ramp_enable,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [2:0]        sysref_prescale_ratio,
    input wire logic              sysref_master_mode, sysref_pulser_active,
    input wire logic [12:0]       sysref_divide_ratio,
    input wire logic [3:0]        sysref_burst_length,
    input wire logic [9:0]        channel_divide_ratio,
    input wire logic              ramp_limits_active,
    input wire logic [32:0]       ramp_upper_limit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Write decodes and write-data fields
    wire logic        m_wr = reg_write && reg_addr == 7'h47;
    wire logic [2:0]  pre  = reg_wdata[7:5];
    wire logic        rep  = reg_wdata[2];
    wire logic        pls  = reg_wdata[4] & ~reg_wdata[2];
    wire logic [10:0] dv   = reg_wdata[10:0];
    AST_PRE_OK: assert property (
        m_wr && pre inside {3'h1, 3'h2, 3'h4}
        |-> ##2 sysref_prescale_ratio == $past(pre, 2)) else $error("ratio");
    AST_PRE_BAD: assert property (
        m_wr && !(pre inside {3'h1, 3'h2, 3'h4})
        |-> ##2 sysref_prescale_ratio == 3'h0) else $error("bad code");
    AST_ROLE: assert property (
        m_wr |-> ##2 sysref_master_mode == !$past(rep, 2)) else $error("role");
    AST_PULSER: assert property (
        m_wr |-> ##2 sysref_pulser_active == $past(pls, 2)) else $error("pls");
    AST_DIV: assert property (
        reg_write && reg_addr == 7'h48 |-> ##2
        sysref_divide_ratio == 13'h4 + {$past(dv, 2), 1'b0})
        else $error("div");
    AST_BURST: assert property (
        !sysref_pulser_active |-> sysref_burst_length == 4'h0)
        else $error("bu");
    AST_CHANNEL_DIVIDE_CODE: assert property (
        reg_write && reg_addr == 7'h4B && reg_wdata[10:6] > 5'h11
        |-> ##2 channel_divide_ratio == 10'h0) else $error("reserved");
    AST_RAMP: assert property (
        !ramp_enable |=> !ramp_limits_active && ramp_upper_limit == 33'h0)
        else $error("ramp off");
    cover property (m_wr && pre == 3'h1);
    cover property (sysref_pulser_active);
    cover property (ramp_limits_active);
endmodule
bind synth_sysref_channel_divide_code_ramp_cfg synth_cfg_sva u_sva (.clk, .sys_rst,
    .reg_write, .ramp_enable, .reg_addr, .reg_wdata, .sysref_prescale_ratio,
    .sysref_master_mode, .sysref_pulser_active, .sysref_divide_ratio,
    .sysref_burst_length, .channel_divide_ratio, .ramp_limits_active,
    .ramp_upper_limit);

// File: verification/tb_synth_sysref_channel_divide_code_ramp_cfg.sv
// Purpose: Self-checking bench of the configuration bank
// Assumes: Reset high for 8 cycles
// Notes:   Scenario tasks run in sequence
`timescale 1ns/1ps
module tb_synth_sysref_channel_divide_code_ramp_cfg import synth_cfg_pkg::*;;
    logic clk = 0, sys_rst = 1, reg_write = 0, reg_read = 0, ramp_enable = 0;
    logic cap_override_valid = 0, sysref_prescale_valid, sysref_master_mode;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    logic [7:0] last_cap_code = 8'hA5, cap_override_code = 8'h3C;
    logic [2:0] last_core_sel = 3'h5, sysref_prescale_ratio;
    logic [2:0] oscillator_core_sel;
    logic [8:0] last_current_code = 9'h1C3, oscillator_current_code;
    logic sysref_generation_enable, sysref_pulser_active, segment_driver_enable;
    logic channel_divide_valid, fast_recal_enable, ramp_limits_active;
    logic [12:0] sysref_divide_ratio;
    logic [5:0] sysref_delay_weight_1, sysref_delay_weight_2;
    logic [5:0] sysref_delay_weight_3, sysref_delay_weight_4;
    logic [3:0] sysref_burst_length;
    logic [9:0] channel_divide_ratio;
    logic [7:0] oscillator_cap_code;
    logic [32:0] ramp_recal_threshold, ramp_upper_limit, ramp_lower_limit;
    wire logic [23:0] weights = {sysref_delay_weight_4, sysref_delay_weight_3,
                                 sysref_delay_weight_2, sysref_delay_weight_1};
    int failures = 0, n_compared = 0, cyc = 0;
    localparam logic [9:0] TAB [18] = '{10'h2, 10'h4, 10'h6, 10'h8, 10'hC,
        10'h10, 10'h18, 10'h20, 10'h30, 10'h40, 10'h48, 10'h60, 10'h80,
        10'hC0, 10'h100, 10'h180, 10'h200, 10'h300};
    synth_sysref_channel_divide_code_ramp_cfg dut (.*);
    always #5 clk = ~clk;
    always @(posedge clk) if (++cyc > 3000) begin
        failures++;
        report_and_stop();
    end
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
        @(posedge clk); reg_write <= 1'b0; @(posedge clk); #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        reg_addr <= a; reg_read <= 1'b1;
        @(posedge clk); reg_read <= 1'b0; #1 chk(reg_rdata, e);
        @(posedge clk); #1;
    endtask
    task automatic t_sysref;
        for (int i = 0; i < 15; i++) rd(REG_OFFSET[i], REG_RESET[i]);
        chk(sysref_prescale_ratio, 4);
        chk(sysref_divide_ratio, 4);
        chk(weights, 24'h00003F);
        rd(7'h57, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr(7'h47, 16'h0018 | (i << 5));
            chk({sysref_prescale_valid, sysref_prescale_ratio},
                i inside {1, 2, 4} ? 8 + i : 0);
        end
        wr(7'h4A, 16'h5000);
        chk(sysref_pulser_active, 1);
        chk(sysref_burst_length, 5);
        wr(7'h47, 16'h001C);
        chk({sysref_master_mode, sysref_generation_enable}, 1);
        chk(sysref_burst_length, 0);
        wr(7'h48, 16'hFFFF);
        chk(sysref_divide_ratio, 13'h1002);
        wr(7'h49, 16'h0FFF);
        rd(7'h57, 16'h0005);
        wr(7'h49, 16'h085E);
        chk(weights, 24'h00085E);
        rd(7'h57, 16'h0001);
        wr(7'h20, 16'hFFFF);
        rd(7'h20, 16'h0000);
    endtask
    task automatic t_channel_divide_code_cal;
        for (int c = 0; c < 20; c++) begin
            wr(7'h4B, c << 6);
            chk({channel_divide_valid, channel_divide_ratio},
                c < 18 ? {1'b1, TAB[c]} : 11'h000);
        end
        rd(7'h57, 16'h0003);
        wr(7'h4B, 16'h00C0);
        rd(7'h57, 16'h0009);
        wr(7'h1F, 16'h4000);
        chk(segment_driver_enable, 1);
        rd(7'h57, 16'h0001);
        wr(7'h4E, 16'h0281);
        @(posedge clk); #1 chk(oscillator_cap_code, 8'hA5);
        chk({fast_recal_enable, oscillator_core_sel,
             oscillator_current_code}, 13'h1BC3);
        wr(7'h4E, 16'h0081);
        @(posedge clk); #1 chk(oscillator_cap_code, 8'h40);
        cap_override_valid <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(oscillator_cap_code, 8'h3C);
        wr(7'h4E, 16'h0171);
        rd(7'h57, 16'h0011);
    endtask
    task automatic t_ramp;
        ramp_enable <= 1'b1;
        wr(7'h51, 16'h0001); wr(7'h52, 16'hABCD); wr(7'h53, 16'h1234);
        wr(7'h54, 16'h0001); wr(7'h56, 16'h0005);
        wr(7'h4E, 16'h0801); wr(7'h4F, 16'h0001); wr(7'h50, 16'h0002);
        chk(ramp_upper_limit, 33'h1ABCD1234);
        chk(ramp_lower_limit, 33'h100000005);
        chk(ramp_recal_threshold, 33'h100010002);
        chk(ramp_limits_active, 1);
        ramp_enable <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({ramp_limits_active, ramp_upper_limit}, 0);
        chk(ramp_lower_limit, 0);
    endtask
    task automatic report_and_stop;
        $display("failures=%0d compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk); #1;
        t_sysref();
        t_channel_divide_code_cal();
        t_ramp();
        report_and_stop();
    end
endmodule
